// ==== src/mcs_channel_select.sv ====
// mcs_channel_select: command word decode, channel disables and bounds limits
// assumes: maintenance words arrive on sys_clk with one-cycle write strobes;
// channel buffer and memory request strobes come from logic on the same clock
// every output is registered; a word's effect shows two edges after its write
//
// Overview of operation
// - external-flag bit raises flag on selected channel
// - codes one to twelve pick a channel
// - word bit 7 is the code's lsb
// - all-channels bit applies operation to every channel
// - flag tells attached device to autoload
// - first word bit E swaps 262K section
// - first word bit F swaps 524K section
// - second word bits 1-12 are channel disables
// - disabled channel gets no memory references
// - disabled channel still moves buffer data
// - disabled channel buffer wraps at last word
// - second word bit E picks lower/upper bound
// - second word bit F is bound msb
// - bounds address word is low 16 bits
// - hit only strictly between lower and upper
`timescale 1ns/1ps
`default_nettype none

module mcs_channel_select #(
  parameter int NUM_CHAN = mcs_pkg::NUM_CHAN,
  parameter int BUF_WORDS = mcs_pkg::BUF_WORDS,
  parameter int PTR_W = $clog2(BUF_WORDS)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,

  // maintenance channel words
  input wire logic [15:0] cmdData,
  input wire logic cmdWrite,
  input wire logic disWrite,
  input wire logic boundsWrite,

  // external flags, bit 0 is channel 1
  output logic [NUM_CHAN-1:0] extFlag,

  // memory degradation swaps
  output logic swap262,
  output logic swap524,

  // storage access controller
  output logic [NUM_CHAN-1:0] chanDisable,
  input wire logic [NUM_CHAN-1:0] memReq,
  output logic [NUM_CHAN-1:0] memGrant,
  output logic [NUM_CHAN-1:0] memRefused,

  // channel buffers
  input wire logic [NUM_CHAN-1:0] bufMove,
  output logic [NUM_CHAN*PTR_W-1:0] bufAddr,
  output logic [NUM_CHAN-1:0] bufWrapped,

  // bounds limits and probe
  output logic [16:0] lowerBound,
  output logic [16:0] upperBound,
  input wire logic [16:0] probeAddr,
  input wire logic probeValid,
  output logic boundsHit
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // bit 7 of the word is the lsb, so the raw field is reversed
  function automatic logic [3:0] sel_code(input logic [3:0] raw);
    sel_code = {raw[0], raw[1], raw[2], raw[3]};
  endfunction : sel_code

  // true when the code names channel number chan (1-based)
  function automatic logic code_hits(input logic [3:0] code, input int chan);
    logic inRange;
    inRange = (code >= mcs_pkg::CODE_FIRST) && (code <= mcs_pkg::CODE_LAST);
    code_hits = inRange && (code == 4'(chan));
  endfunction : code_hits

  // true only strictly between the limits; equal to either one is outside
  function automatic logic strictly_inside(input logic [16:0] a, input logic [16:0] lo,
    input logic [16:0] hi);
    strictly_inside = (a > lo) && (a < hi);
  endfunction : strictly_inside

  // ----------------------------------------------------------------
  // incoming word views
  // ----------------------------------------------------------------
  // the write bus read through each word's layout, so no bit position
  // is spelled out by hand further down
  mcs_pkg::mcs_cmd_s cmdIn;
  mcs_pkg::mcs_dis_s disIn;

  assign cmdIn = cmdData;
  assign disIn = cmdData;

  // ----------------------------------------------------------------
  // command word storage
  // ----------------------------------------------------------------
  mcs_pkg::mcs_cmd_s cmdWord;
  mcs_pkg::mcs_dis_s disWord;
  mcs_pkg::mcs_bound_s lowerReg;
  mcs_pkg::mcs_bound_s upperReg;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cmdWord <= mcs_pkg::CMD_RESET;
    end else if (cmdWrite) begin
      cmdWord <= cmdIn;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      disWord <= mcs_pkg::DIS_RESET;
    end else if (disWrite) begin
      disWord <= disIn;
    end
  end

  // ----------------------------------------------------------------
  // bounds limits
  // ----------------------------------------------------------------
  // the msb comes from the disable word and the low half from the
  // bounds word; either may arrive first, each lands in the bound
  // that the selector picks at the time of its own write
  logic writeUpperSel;
  logic lowerMsbWrite;
  logic upperMsbWrite;
  logic lowerLowWrite;
  logic upperLowWrite;

  assign writeUpperSel = disWrite ? disIn.upperSel : disWord.upperSel;
  assign lowerMsbWrite = disWrite && !writeUpperSel;
  assign upperMsbWrite = disWrite && writeUpperSel;
  assign lowerLowWrite = boundsWrite && !writeUpperSel;
  assign upperLowWrite = boundsWrite && writeUpperSel;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerReg <= mcs_pkg::LOWER_RESET;
    end else begin
      if (lowerMsbWrite) begin
        lowerReg.msb <= disIn.boundsMsb;
      end
      if (lowerLowWrite) begin
        lowerReg.low <= cmdData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upperReg <= mcs_pkg::UPPER_RESET;
    end else begin
      if (upperMsbWrite) begin
        upperReg.msb <= disIn.boundsMsb;
      end
      if (upperLowWrite) begin
        upperReg.low <= cmdData;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lowerBound <= mcs_pkg::LOWER_RESET;
    end else begin
      lowerBound <= lowerReg;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      upperBound <= mcs_pkg::UPPER_RESET;
    end else begin
      upperBound <= upperReg;
    end
  end

  // strict on both sides: an address equal to a limit is not a hit
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      boundsHit <= 1'b0;
    end else begin
      boundsHit <= probeValid && strictly_inside(probeAddr, lowerReg, upperReg);
    end
  end

  // ----------------------------------------------------------------
  // memory degradation swaps
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      swap262 <= 1'b0;
    end else begin
      swap262 <= cmdWord.swap262;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      swap524 <= 1'b0;
    end else begin
      swap524 <= cmdWord.swap524;
    end
  end

  // ----------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------
  // only the external-flag bit drives anything; the other op bits, the
  // phase bit and the spare fields are stored but never read
  logic [3:0] code;
  assign code = sel_code(cmdWord.selRaw);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      logic [PTR_W-1:0] ptr;
      logic atLast;
      logic chosen;
      logic flagNow;
      logic [PTR_W-1:0] next_ptr;

      // channel numbers are 1-based on the select code
      assign chosen = cmdWord.allChan || code_hits(code, ch + 1);
      assign atLast = (ptr == PTR_W'(BUF_WORDS - 1));
      assign flagNow = cmdWord.sendFlag && chosen;

      // level flag: held while the op bit stays set; the device reads
      // it as an autoload request
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          extFlag[ch] <= 1'b0;
        end else begin
          extFlag[ch] <= flagNow;
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          chanDisable[ch] <= 1'b0;
        end else begin
          chanDisable[ch] <= disWord.chanOff[ch];
        end
      end

      // grants follow the stored disable so no request slips through
      // in the cycle the disable output itself updates
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          memGrant[ch] <= 1'b0;
        end else begin
          memGrant[ch] <= memReq[ch] && !disWord.chanOff[ch];
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          memRefused[ch] <= 1'b0;
        end else begin
          memRefused[ch] <= memReq[ch] && disWord.chanOff[ch];
        end
      end

      // buffer pointer runs regardless of the disable; wraps to start
      // instead of running past the end of the buffer area
      always_comb begin
        next_ptr = ptr;
        if (bufMove[ch]) begin
          next_ptr = atLast ? '0 : ptr + 1'b1;
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          ptr <= '0;
        end else begin
          ptr <= next_ptr;
        end
      end

      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          bufWrapped[ch] <= 1'b0;
        end else begin
          bufWrapped[ch] <= bufMove[ch] && atLast;
        end
      end

      assign bufAddr[ch*PTR_W +: PTR_W] = ptr;
    end
  endgenerate

endmodule : mcs_channel_select

`default_nettype wire

// ==== src/mcs_pkg.sv ====
// mcs_pkg: constants and word layouts for the maintenance channel select block
// assumes: 16-bit command words, twelve i/o channels, 17-bit bounds addresses
package mcs_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int NUM_CHAN = 12;
  localparam int ADDR_W = 17;
  localparam int CODE_W = 4;
  localparam int BUF_WORDS = 64;

  // ----------------------------------------------------------------
  // channel select codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_FIRST = 4'h1;
  localparam logic [3:0] CODE_LAST = 4'hc;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0000;
  localparam logic [15:0] DIS_RESET = 16'h0000;
  localparam logic [16:0] LOWER_RESET = 17'h00000;
  localparam logic [16:0] UPPER_RESET = 17'h00000;

  // channel command word, msb first
  typedef struct packed {
    logic swap524;
    logic swap262;
    logic phase16;
    logic [3:0] spareHi;
    logic allChan;
    logic [3:0] selRaw;
    logic [1:0] opSpare;
    logic sendFlag;
    logic spare0;
  } mcs_cmd_s;

  // channel disable and bounds word, msb first
  typedef struct packed {
    logic boundsMsb;
    logic upperSel;
    logic spareD;
    logic [11:0] chanOff;
    logic spare0;
  } mcs_dis_s;

  // one bounds limit
  typedef struct packed {
    logic msb;
    logic [15:0] low;
  } mcs_bound_s;

endpackage : mcs_pkg

// ==== tb/mcs_channel_select_props.sv ====
// checker: output timing of the channel select block against its inputs
// assumes: bound to the top module, one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module mcs_channel_select_props #(parameter int NUM_CHAN = 12) (
  // clock and words
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [15:0] cmdData,
  input wire logic cmdWrite,
  input wire logic disWrite,
  input wire logic boundsWrite,
  // channel outputs
  input wire logic [NUM_CHAN-1:0] extFlag,
  input wire logic swap262,
  input wire logic swap524,
  input wire logic [NUM_CHAN-1:0] chanDisable,
  input wire logic [NUM_CHAN-1:0] memReq,
  input wire logic [NUM_CHAN-1:0] memGrant,
  input wire logic [NUM_CHAN-1:0] memRefused,
  // bounds
  input wire logic [16:0] lowerBound,
  input wire logic [16:0] upperBound,
  input wire logic [16:0] probeAddr,
  input wire logic probeValid,
  input wire logic boundsHit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // word bit 7 is the code lsb, so the nibble is read reversed
  function automatic logic [11:0] pick(input logic [15:0] d);
    logic [3:0] c;
    c = {d[4], d[5], d[6], d[7]};
    pick = (c >= 4'h1 && c <= 4'hc) ? 12'h001 << (c - 4'h1) : 12'h000;
  endfunction : pick
  a_flag_pick: assert property (cmdWrite && cmdData[1] && !cmdData[8] |-> ##2 extFlag == pick($past(cmdData, 2)))
    else $error("flag on wrong channel");
  a_flag_all: assert property (cmdWrite && cmdData[1] && cmdData[8] |-> ##2 &extFlag)
    else $error("all-channel flag missing");
  a_flag_off: assert property (cmdWrite && !cmdData[1] |-> ##2 extFlag == '0)
    else $error("flag without send bit");
  a_swap_bits: assert property (cmdWrite |-> ##2 {swap524, swap262} == $past(cmdData[15:14], 2))
    else $error("swap outputs differ from word");
  a_dis_bits: assert property (disWrite |-> ##2 chanDisable == $past(cmdData[12:1], 2))
    else $error("disable lines differ from word");
  a_grant_mask: assert property (memGrant == ($past(memReq) & ~chanDisable))
    else $error("grant on wrong channels");
  a_refuse_mask: assert property (memRefused == ($past(memReq) & chanDisable))
    else $error("refusal on wrong channels");
  a_hit_strict: assert property (boundsHit == ($past(probeValid) && lowerBound < $past(probeAddr) && $past(probeAddr) < upperBound))
    else $error("bounds hit wrong");
  a_bound_low: assert property (boundsWrite |-> ##2 (lowerBound[15:0] == $past(cmdData, 2) || upperBound[15:0] == $past(cmdData, 2)))
    else $error("bounds low half not loaded");
  c_flag: cover property (cmdWrite && cmdData[1]);
  c_refused: cover property (|memRefused);
  c_hit: cover property (boundsHit);
endmodule : mcs_channel_select_props
bind mcs_channel_select mcs_channel_select_props #(.NUM_CHAN(NUM_CHAN)) props (
  .sys_clk(sys_clk), .resetn(resetn), .cmdData(cmdData), .cmdWrite(cmdWrite),
  .disWrite(disWrite), .boundsWrite(boundsWrite), .extFlag(extFlag), .swap262(swap262),
  .swap524(swap524), .chanDisable(chanDisable), .memReq(memReq), .memGrant(memGrant),
  .memRefused(memRefused), .lowerBound(lowerBound), .upperBound(upperBound),
  .probeAddr(probeAddr), .probeValid(probeValid), .boundsHit(boundsHit));
`default_nettype wire

// ==== tb/mcs_maint_station.sv ====
// maintenance station model: issues command words with one-cycle strobes
// assumes: strobes sampled on the rising edge, changed on the falling edge
`timescale 1ns/1ps
`default_nettype none
module mcs_maint_station (
  input wire logic sys_clk,
  output logic [15:0] cmdData = 16'h0000,
  output logic cmdWrite = 1'b0,
  output logic disWrite = 1'b0,
  output logic boundsWrite = 1'b0
);
  // which: 0 command word, 1 disable word, 2 bounds address word
  task automatic put(input int which, input logic [15:0] d);
    @(negedge sys_clk);
    cmdData = d;
    cmdWrite = (which == 0);
    disWrite = (which == 1);
    boundsWrite = (which == 2);
    @(negedge sys_clk);
    {cmdWrite, disWrite, boundsWrite} = 3'h0;
    cmdData = ~d; // idle word is junk, never the last value
  endtask : put
  task automatic send(input logic [15:0] d);
    put(0, d & 16'hfffd);
    put(0, d | 16'h0002);
  endtask : send
  task automatic bound(input logic up, input logic [16:0] a);
    put(1, {a[16], up, 14'h0000});
    put(2, a[15:0]);
  endtask : bound
endmodule : mcs_maint_station
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: drives the channel select block and checks its outputs
// assumes: package and design compiled first; small buffer for short wraps
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PW = 2;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] cmdData;
  logic cmdWrite, disWrite, boundsWrite, swap262, swap524, boundsHit;
  logic probeValid = 1'b0;
  logic [11:0] memReq = 12'h000;
  logic [11:0] bufMove = 12'h000;
  logic [11:0] extFlag, chanDisable, memGrant, memRefused, bufWrapped;
  logic [16:0] probeAddr = 17'h00000;
  logic [16:0] lowerBound, upperBound;
  logic [12*PW-1:0] bufAddr;
  int nErrors = 0;
  int totalChecks = 0;
  int cyc = 0;
  always #5 sys_clk = ~sys_clk;
  mcs_maint_station station (.sys_clk(sys_clk), .cmdData(cmdData), .cmdWrite(cmdWrite),
    .disWrite(disWrite), .boundsWrite(boundsWrite));
  mcs_channel_select #(.BUF_WORDS(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .cmdData(cmdData), .cmdWrite(cmdWrite), .disWrite(disWrite), .boundsWrite(boundsWrite),
    .extFlag(extFlag), .swap262(swap262), .swap524(swap524), .chanDisable(chanDisable),
    .memReq(memReq), .memGrant(memGrant), .memRefused(memRefused), .bufMove(bufMove),
    .bufAddr(bufAddr), .bufWrapped(bufWrapped), .lowerBound(lowerBound),
    .upperBound(upperBound), .probeAddr(probeAddr), .probeValid(probeValid),
    .boundsHit(boundsHit));
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrapUp();
    if (nErrors == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrapUp
  task automatic t_flags();
    logic [3:0] k;
    logic [15:0] d;
    for (int c = 0; c < 16; c++) begin
      k = c[3:0];
      d = 16'h1e0d | {8'h00, k[0], k[1], k[2], k[3], 4'h0}; // spare bits set
      station.send(d);
      repeat (2) @(negedge sys_clk);
      chk("extFlag", extFlag, (c >= 1 && c <= 12) ? 12'h001 << (c - 1) : 12'h000);
      station.put(0, d);
    end
    station.send(16'h0100);
    repeat (2) @(negedge sys_clk);
    chk("extFlagAll", extFlag, 12'hfff);
    station.put(0, 16'h0100);
    station.put(0, 16'hc000);
    repeat (2) @(negedge sys_clk);
    chk("swaps", {swap524, swap262, extFlag}, {2'b11, 12'h000});
  endtask : t_flags
  task automatic t_disable();
    station.put(1, {3'b001, 12'ha5b, 1'b1});
    repeat (2) @(negedge sys_clk);
    chk("chanDisable", chanDisable, 12'ha5b);
    memReq = 12'hfff;
    @(negedge sys_clk);
    memReq = 12'h000;
    chk("memGrant", memGrant, 12'h5a4);
    chk("memRefused", memRefused, 12'ha5b);
  endtask : t_disable
  task automatic t_buffer();
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(negedge sys_clk);
      bufMove = {11'h000, i < 4};
      seen |= bufWrapped[0];
      if (i == 3) chk("bufAddr0Mid", bufAddr[PW-1:0], 24'h3);
    end
    chk("bufAddr0", bufAddr[PW-1:0], 24'h0);
    chk("bufWrapped0", seen, 1'b1);
  endtask : t_buffer
  task automatic probe(input logic [16:0] a, input logic hit);
    @(negedge sys_clk);
    probeValid = 1'b1;
    probeAddr = a;
    @(negedge sys_clk);
    probeValid = 1'b0;
    chk("boundsHit", boundsHit, hit);
  endtask : probe
  task automatic t_bounds();
    station.bound(1'b0, 17'h00010);
    station.bound(1'b1, 17'h10005);
    repeat (2) @(negedge sys_clk);
    chk("lowerBound", lowerBound, 17'h00010);
    chk("upperBound", upperBound, 17'h10005);
    probe(17'h00010, 1'b0);
    probe(17'h00011, 1'b1);
    probe(17'h10004, 1'b1);
    probe(17'h10005, 1'b0);
  endtask : t_bounds
  initial begin
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    chk("resetOutputs", {extFlag, chanDisable}, 24'h0);
    t_flags();
    t_disable();
    t_buffer();
    t_bounds();
    wrapUp();
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      nErrors++;
      wrapUp();
    end
  end
endmodule : testbench
`default_nettype wire
